// ---- include/dcc_regs.svh ----
// Purpose: register offsets, field positions and reset values of the dual comparator control block
// Assumes: AXI4-Lite word-aligned byte addressing, 32-bit data
// Notes: offsets are byte addresses
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH

`define DCC_ADDR_W 6
// register byte offsets
`define DCC_OFF_CONFIG 6'h00
`define DCC_OFF_FLAGS 6'h04
`define DCC_OFF_FORCE 6'h08
`define DCC_OFF_GATE 6'h0C
`define DCC_OFF_MASKED 6'h10
`define DCC_OFF_STATE 6'h14
`define DCC_OFF_CTRL0 6'h18
`define DCC_OFF_CTRL1 6'h1C
`define DCC_OFF_EVT_EN 6'h20
`define DCC_OFF_EVT_CLR 6'h24
// control register fields
`define DCC_PWR_LO 0
`define DCC_PWR_HI 1
`define DCC_HYST_BIT 5
`define DCC_EDGE_LO 6
`define DCC_EDGE_HI 7
`define DCC_CTRL_MASK 32'h0000_00E3
// global enable and level positions
`define DCC_GEN_BIT 31
`define DCC_LVL1_BIT 16
// reset values
`define DCC_CTRL_RST 32'h0000_0000
`define DCC_CFG_RST 1'h0
// axi response codes
`define DCC_RESP_OKAY 2'h0
`define DCC_RESP_SLVERR 2'h2

`endif

// ---- include/dcc_pkg.sv ----
// Purpose: types of the dual comparator control block
// Assumes: nothing
// Notes: codes follow the control register encodings
package dcc_pkg;
    // power selection codes
    typedef enum logic [1:0] {
        DCC_PWR_OFF = 2'h0,
        DCC_PWR_ULP = 2'h1,
        DCC_PWR_LP = 2'h2,
        DCC_PWR_NORMAL = 2'h3
    } dcc_pwr_t;
    // edge selection codes
    typedef enum logic [1:0] {
        DCC_EDGE_NONE = 2'h0,
        DCC_EDGE_RISE = 2'h1,
        DCC_EDGE_FALL = 2'h2,
        DCC_EDGE_BOTH = 2'h3
    } dcc_edge_t;
    // read channel state
    typedef enum logic [0:0] {
        DCC_RD_IDLE = 1'b0,
        DCC_RD_RESP = 1'b1
    } dcc_rd_t;
endpackage

// ---- design/dcc_top.sv ----
// Purpose: register file, synchronisers, edge detect and interrupt logic for two low-power comparators
// Assumes: comparator outputs are asynchronous; aclk is the system main clock
// Notes: analog cores sit outside; this block only drives their control lines
`timescale 1ns/10ps
`include "dcc_regs.svh"

module dcc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] cmp_raw,
    output logic [1:0] cmp0_power_select,
    output logic [1:0] cmp1_power_select,
    output logic cmp0_hysteresis_on,
    output logic cmp1_hysteresis_on,
    output logic cmp_irq,
    output logic cmp_wakeup,
    output logic evt_irq
);

    // registers steered by software
    logic gen_q; // global enable
    logic [31:0] ctrl_q [2]; // per comparator control
    logic [1:0] gate_q; // interrupt mask
    logic [1:0] flag_q; // sticky interrupt flags
    logic [1:0] evt_st_q; // event status (edge seen)
    logic [1:0] evt_en_q; // event enable
    // synchroniser stages and history
    logic [1:0] sync1_q; // first stage, read only by sync2
    logic [1:0] sync2_q; // synchronised level
    logic [1:0] prev_q; // previous synchronised level
    // derived events
    logic [1:0] edge_hit;
    logic [1:0] masked;

    // per comparator edge detection
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_cmp
            wire [1:0] esel = ctrl_q[gi][`DCC_EDGE_HI:`DCC_EDGE_LO];
            wire rise = sync2_q[gi] & ~prev_q[gi];
            wire fall = ~sync2_q[gi] & prev_q[gi];
            // disabled edge select or global off blocks the event
            assign edge_hit[gi] = gen_q & (((esel == dcc_pkg::DCC_EDGE_RISE) & rise)
                | ((esel == dcc_pkg::DCC_EDGE_FALL) & fall)
                | ((esel == dcc_pkg::DCC_EDGE_BOTH) & (rise | fall)));
            // only gated flags reach the cpu
            assign masked[gi] = flag_q[gi] & gate_q[gi];
        end
    endgenerate

    // two-stage synchroniser on the main clock; no sleep gating, runs in every mode
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            prev_q <= 2'h0;
        end
        else
        begin
            sync1_q <= cmp_raw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // write channel: address and data taken in either order, response after both
    logic aw_got_q;
    logic w_got_q;
    logic [5:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic awready_q; // registered ready, address half
    logic wready_q; // registered ready, data half
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire [5:0] wa = aw_take ? s_axi_awaddr : awaddr_q;
    wire [31:0] wd = w_take ? s_axi_wdata : wdata_q;
    wire [3:0] ws = w_take ? s_axi_wstrb : wstrb_q;
    wire do_wr = (aw_got_q | aw_take) & (w_got_q | w_take) & ~bvalid_q;
    wire aw_got_d = do_wr ? 1'b0 : (aw_got_q | aw_take);
    wire w_got_d = do_wr ? 1'b0 : (w_got_q | w_take);
    wire bvalid_d = do_wr | (bvalid_q & ~s_axi_bready);
    // byte-enable merge: full word mask from strobes
    wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
    wire wr_cfg = do_wr & (wa == `DCC_OFF_CONFIG);
    wire wr_flag = do_wr & (wa == `DCC_OFF_FLAGS);
    wire wr_force = do_wr & (wa == `DCC_OFF_FORCE);
    wire wr_gate = do_wr & (wa == `DCC_OFF_GATE);
    wire wr_ctrl0 = do_wr & (wa == `DCC_OFF_CTRL0);
    wire wr_ctrl1 = do_wr & (wa == `DCC_OFF_CTRL1);
    wire wr_een = do_wr & (wa == `DCC_OFF_EVT_EN);
    wire wr_eclr = do_wr & (wa == `DCC_OFF_EVT_CLR);
    wire wr_ro = do_wr & ((wa == `DCC_OFF_MASKED) | (wa == `DCC_OFF_STATE));
    wire wr_ok = wr_cfg | wr_flag | wr_force | wr_gate | wr_ctrl0 | wr_ctrl1 | wr_een | wr_eclr | wr_ro;
    wire [31:0] wbits = wd & wmask;

    // write handshake state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 6'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `DCC_RESP_OKAY;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
        end
        else
        begin
            if (aw_take)
            begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            // holding flags clear once the write commits
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            bvalid_q <= bvalid_d;
            awready_q <= ~aw_got_d & ~bvalid_d;
            wready_q <= ~w_got_d & ~bvalid_d;
            if (do_wr)
            begin
                bresp_q <= wr_ok ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
            end
        end
    end
    // one write at a time; ready leaves a flop, so it is low for one cycle after reset
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // configuration registers; only implemented control bits are kept
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gen_q <= `DCC_CFG_RST;
            ctrl_q[0] <= `DCC_CTRL_RST;
            ctrl_q[1] <= `DCC_CTRL_RST;
            gate_q <= 2'h0;
            evt_en_q <= 2'h0;
        end
        else
        begin
            if (wr_cfg & ws[3])
            begin
                gen_q <= wd[`DCC_GEN_BIT];
            end
            if (wr_ctrl0)
            begin
                ctrl_q[0] <= ((ctrl_q[0] & ~wmask) | wbits) & `DCC_CTRL_MASK;
            end
            if (wr_ctrl1)
            begin
                ctrl_q[1] <= ((ctrl_q[1] & ~wmask) | wbits) & `DCC_CTRL_MASK;
            end
            if (wr_gate & ws[0])
            begin
                gate_q <= wd[1:0];
            end
            if (wr_een & ws[0])
            begin
                evt_en_q <= wd[1:0];
            end
        end
    end

    // sticky flags: hardware set and force win over write-one clear
    wire [1:0] flag_clr = wr_flag ? wbits[1:0] : 2'h0;
    wire [1:0] flag_set = edge_hit | (wr_force ? wbits[1:0] : 2'h0);
    wire [1:0] est_clr = wr_eclr ? wbits[1:0] : 2'h0;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flag_q <= 2'h0;
            evt_st_q <= 2'h0;
        end
        else
        begin
            flag_q <= (flag_q & ~flag_clr) | flag_set;
            evt_st_q <= (evt_st_q & ~est_clr) | edge_hit;
        end
    end

    // outputs registered; wakeup shares the masked qualification
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cmp_irq <= 1'b0;
            cmp_wakeup <= 1'b0;
            evt_irq <= 1'b0;
            cmp0_power_select <= 2'h0;
            cmp1_power_select <= 2'h0;
            cmp0_hysteresis_on <= 1'b0;
            cmp1_hysteresis_on <= 1'b0;
        end
        else
        begin
            cmp_irq <= |masked;
            cmp_wakeup <= |(masked & {ctrl_q[1][`DCC_EDGE_HI:`DCC_EDGE_LO] != 2'h0,
                ctrl_q[0][`DCC_EDGE_HI:`DCC_EDGE_LO] != 2'h0}) & gen_q;
            evt_irq <= |(evt_st_q & evt_en_q);
            // global disable powers both comparators down
            cmp0_power_select <= gen_q ? ctrl_q[0][`DCC_PWR_HI:`DCC_PWR_LO] : 2'h0;
            cmp1_power_select <= gen_q ? ctrl_q[1][`DCC_PWR_HI:`DCC_PWR_LO] : 2'h0;
            cmp0_hysteresis_on <= ctrl_q[0][`DCC_HYST_BIT];
            cmp1_hysteresis_on <= ctrl_q[1][`DCC_HYST_BIT];
        end
    end

    // read channel
    dcc_pkg::dcc_rd_t rd_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic arready_q; // registered address ready
    wire ar_take = s_axi_arvalid & s_axi_arready;
    logic [31:0] rmux;
    logic rhit;
    // read mux; state register shows synchronised levels
    always_comb
    begin
        rmux = 32'h0000_0000;
        rhit = 1'b1;
        unique case (s_axi_araddr)
            `DCC_OFF_CONFIG: rmux[`DCC_GEN_BIT] = gen_q;
            `DCC_OFF_FLAGS: rmux[1:0] = flag_q;
            `DCC_OFF_FORCE: rmux[1:0] = flag_q;
            `DCC_OFF_GATE: rmux[1:0] = gate_q;
            `DCC_OFF_MASKED: rmux[1:0] = masked;
            `DCC_OFF_STATE:
            begin
                rmux[0] = sync2_q[0];
                rmux[`DCC_LVL1_BIT] = sync2_q[1];
            end
            `DCC_OFF_CTRL0: rmux = ctrl_q[0];
            `DCC_OFF_CTRL1: rmux = ctrl_q[1];
            `DCC_OFF_EVT_EN: rmux[1:0] = evt_en_q;
            `DCC_OFF_EVT_CLR: rmux[1:0] = evt_st_q;
            default: rhit = 1'b0;
        endcase
    end
    // read answer one cycle after address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_q <= dcc_pkg::DCC_RD_IDLE;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `DCC_RESP_OKAY;
            arready_q <= 1'b0;
        end
        else
        begin
            arready_q <= (rd_q == dcc_pkg::DCC_RD_IDLE) ? ~ar_take : s_axi_rready;
            unique case (rd_q)
                dcc_pkg::DCC_RD_IDLE:
                    if (ar_take)
                    begin
                        rd_q <= dcc_pkg::DCC_RD_RESP;
                        rdata_q <= rmux;
                        rresp_q <= rhit ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
                    end
                dcc_pkg::DCC_RD_RESP:
                    if (s_axi_rready)
                    begin
                        rd_q <= dcc_pkg::DCC_RD_IDLE;
                    end
            endcase
        end
    end
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = (rd_q == dcc_pkg::DCC_RD_RESP);
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // checks
    AST_IRQ_OR: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 cmp_irq == |($past(flag_q) & $past(gate_q)))
        else $error("shared irq not or of masked flags");
    AST_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        edge_hit[0] |=> flag_q[0])
        else $error("edge did not set flag 0");
    AST_SYNC_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn ##1 aresetn |=> sync2_q == $past(cmp_raw, 2))
        else $error("synchroniser not two stages");
    AST_GEN_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        !gen_q && !wr_force |=> (flag_q & ~$past(flag_q)) == 2'h0)
        else $error("flag set with system disabled");
    AST_EDGE_NONE: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_q[1][7:6] == 2'h0 |-> !edge_hit[1])
        else $error("disabled edge raised event");
    AST_WAKE_QUAL: assert property (@(posedge aclk) disable iff (!aresetn)
        cmp_wakeup |-> $past(gen_q) && $past(|masked))
        else $error("wakeup without qualification");
    AST_WAKE_RISE: assert property (@(posedge aclk) disable iff (!aresetn)
        (edge_hit[0] && gate_q[0] && ctrl_q[0][7:6] != 2'h0) |-> ##2 cmp_wakeup)
        else $error("qualified event gave no wakeup");
    AST_HYST: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 cmp1_hysteresis_on == $past(ctrl_q[1][5]))
        else $error("hysteresis not following bit 5");
    AST_PWR: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 cmp0_power_select == ($past(gen_q) ? $past(ctrl_q[0][1:0]) : 2'h0))
        else $error("power select mismatch");
    AST_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_take && s_axi_araddr == 6'h14) |=> rdata_q[16] == $past(sync2_q[1]))
        else $error("state bit 16 wrong");

endmodule

// ---- sim/dcc_cpu_model.sv ----
// Purpose: cpu-side partner that takes the shared interrupt and the wakeup request
// Assumes: deep_sleep is driven by the bench in place of the power controller
// Notes: behavioural; latches a wakeup only while asleep
`timescale 1ns/10ps

module dcc_cpu_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic deep_sleep,
    input wire logic cmp_irq,
    input wire logic cmp_wakeup,
    output logic woke_q,
    output logic irq_seen_q
);
    // sticky records, cleared only by reset so a short request is never lost
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            woke_q <= 1'b0;
            irq_seen_q <= 1'b0;
        end
        else
        begin
            // wakeup honoured only while asleep, as the wakeup controller would
            if (deep_sleep && cmp_wakeup)
                woke_q <= 1'b1;
            if (cmp_irq)
                irq_seen_q <= 1'b1;
        end
    end
endmodule

// ---- sim/dual_comparator_control_test.sv ----
// Purpose: self-checking bench for the comparator control block
// Assumes: flags settle within 8 edges of a comparator change
// Notes: random ctrl values and comparator levels from a fixed seed
`timescale 1ns/10ps
`include "dcc_regs.svh"

module dual_comparator_control_test;
    logic aclk, aresetn;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_val, v;
    logic [1:0] s_axi_bresp, s_axi_rresp, cmp_raw, p0, p1;
    logic h0, h1, cmp_irq, cmp_wakeup, evt_irq, deep_sleep, woke, irq_seen;
    logic [5:0] off;
    int errors, check_count, seed;

    dcc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cmp_raw(cmp_raw),
        .cmp0_power_select(p0), .cmp1_power_select(p1), .cmp0_hysteresis_on(h0),
        .cmp1_hysteresis_on(h1), .cmp_irq(cmp_irq), .cmp_wakeup(cmp_wakeup), .evt_irq(evt_irq));

    dcc_cpu_model cpu (.aclk(aclk), .aresetn(aresetn), .deep_sleep(deep_sleep), .cmp_irq(cmp_irq),
        .cmp_wakeup(cmp_wakeup), .woke_q(woke), .irq_seen_q(irq_seen));

    // free-running 10 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // one place that ends the run
    task automatic give_verdict();
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // single compare for every 32-bit result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // axi write; halves released separately as each is taken
    task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready && s_axi_awvalid)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        // a hung slave ends the run as a failure
        if (!s_axi_bvalid)
        begin
            errors++;
            give_verdict();
        end
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    // axi read; rready held until the data edge
    task automatic axi_rd(input logic [5:0] a, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready && s_axi_arvalid)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'b0;
        rd_val = s_axi_rdata;
        if (!s_axi_rvalid)
        begin
            errors++;
            give_verdict();
        end
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        axi_rd(a, `DCC_RESP_OKAY);
        chk(rd_val, exp);
    endtask

    // comparator move, then enough edges for sync, detect and flag
    task automatic drive_cmp(input logic [1:0] r);
        @(posedge aclk);
        cmp_raw <= r;
        repeat (8) @(posedge aclk);
    endtask

    // expected flag for one edge code and one direction
    function automatic logic hit(input logic [1:0] e, input logic rise);
        return rise ? e[0] : e[1];
    endfunction

    initial
    begin
        seed = 32'hf941;
        errors = 0;
        check_count = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        cmp_raw = 2'h0;
        deep_sleep = 1'b0;
        aresetn = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        // reset state of registers and outputs
        rd_chk(`DCC_OFF_CONFIG, 32'h0);
        rd_chk(`DCC_OFF_CTRL0, `DCC_CTRL_RST);
        chk({23'h0, p0, p1, h0, h1, cmp_irq, cmp_wakeup, evt_irq}, 32'h0);
        axi_wr(`DCC_OFF_CONFIG, 32'h8000_0000, `DCC_RESP_OKAY);
        // every power code, turned off first to avoid output glitches
        for (int p = 0; p < 4; p++)
        begin
            axi_wr(`DCC_OFF_CTRL0, 32'h0, `DCC_RESP_OKAY);
            axi_wr(`DCC_OFF_CTRL0, 32'(p) | (32'(p % 2) << 5), `DCC_RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk({29'h0, h0, p0}, {29'h0, 1'(p % 2), 2'(p)});
        end
        v = $random(seed);
        axi_wr(`DCC_OFF_CTRL1, v, `DCC_RESP_OKAY);
        rd_chk(`DCC_OFF_CTRL1, v & `DCC_CTRL_MASK);
        chk({29'h0, h1, p1}, {29'h0, v[`DCC_HYST_BIT], v[1:0]});
        axi_wr(`DCC_OFF_CONFIG, 32'h0, `DCC_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({30'h0, p0 | p1}, 32'h0);
        // global disable blocks edge events
        axi_wr(`DCC_OFF_CTRL0, 32'hC1, `DCC_RESP_OKAY);
        drive_cmp(2'h1);
        rd_chk(`DCC_OFF_FLAGS, 32'h0);
        drive_cmp(2'h0);
        axi_wr(`DCC_OFF_CONFIG, 32'h8000_0000, `DCC_RESP_OKAY);
        axi_wr(`DCC_OFF_GATE, 32'h3, `DCC_RESP_OKAY);
        // all edge codes on both comparators, rising then falling
        for (int c = 0; c < 2; c++)
        begin
            off = c ? `DCC_OFF_CTRL1 : `DCC_OFF_CTRL0;
            for (int e = 0; e < 4; e++)
            begin
                axi_wr(off, (32'(e) << 6) | 32'h1, `DCC_RESP_OKAY);
                axi_wr(`DCC_OFF_FLAGS, 32'h3, `DCC_RESP_OKAY);
                drive_cmp(2'(1 << c));
                rd_chk(`DCC_OFF_FLAGS, 32'(hit(2'(e), 1'b1)) << c);
                chk({30'h0, cmp_irq, cmp_wakeup}, {30'h0, {2{hit(2'(e), 1'b1)}}});
                axi_wr(`DCC_OFF_FLAGS, 32'h3, `DCC_RESP_OKAY);
                drive_cmp(2'h0);
                rd_chk(`DCC_OFF_FLAGS, 32'(hit(2'(e), 1'b0)) << c);
                axi_wr(`DCC_OFF_FLAGS, 32'h3, `DCC_RESP_OKAY);
            end
        end
        // mask picks which comparator reaches the cpu
        axi_wr(`DCC_OFF_GATE, 32'h1, `DCC_RESP_OKAY);
        axi_wr(`DCC_OFF_EVT_EN, 32'h0, `DCC_RESP_OKAY);
        axi_wr(`DCC_OFF_EVT_CLR, 32'h3, `DCC_RESP_OKAY);
        drive_cmp(2'h2);
        rd_chk(`DCC_OFF_MASKED, 32'h0);
        chk({29'h0, cmp_irq, cmp_wakeup, evt_irq}, 32'h0);
        axi_wr(`DCC_OFF_GATE, 32'h2, `DCC_RESP_OKAY);
        axi_wr(`DCC_OFF_EVT_EN, 32'h3, `DCC_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({29'h0, cmp_irq, cmp_wakeup, evt_irq}, 32'h7);
        axi_wr(`DCC_OFF_EVT_CLR, 32'h3, `DCC_RESP_OKAY);
        axi_wr(`DCC_OFF_FLAGS, 32'h3, `DCC_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({29'h0, cmp_irq, cmp_wakeup, evt_irq}, 32'h0);
        // force register sets a flag without an edge
        axi_wr(`DCC_OFF_FORCE, 32'h2, `DCC_RESP_OKAY);
        rd_chk(`DCC_OFF_FLAGS, 32'h2);
        repeat (3) @(posedge aclk);
        chk({31'h0, cmp_irq}, 32'h1);
        axi_wr(`DCC_OFF_FLAGS, 32'h2, `DCC_RESP_OKAY);
        // mid-run reset with comparator 1 high: registers, pins and cpu records start over
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        chk({30'h0, p0, cmp_irq}, 32'h0);
        rd_chk(`DCC_OFF_CTRL0, `DCC_CTRL_RST);
        rd_chk(`DCC_OFF_FLAGS, 32'h0);
        axi_wr(`DCC_OFF_CONFIG, 32'h8000_0000, `DCC_RESP_OKAY);
        // ultra low-power set before sleep, then a wakeup event
        axi_wr(`DCC_OFF_CTRL0, 32'h0, `DCC_RESP_OKAY);
        axi_wr(`DCC_OFF_CTRL0, 32'h41, `DCC_RESP_OKAY);
        axi_wr(`DCC_OFF_GATE, 32'h1, `DCC_RESP_OKAY);
        chk({30'h0, woke, irq_seen}, 32'h0);
        @(posedge aclk);
        deep_sleep <= 1'b1;
        drive_cmp(2'h1);
        chk({30'h0, woke, irq_seen}, 32'h3);
        deep_sleep <= 1'b0;
        // level readback from random comparator states
        for (int i = 0; i < 6; i++)
        begin
            v = $random(seed);
            drive_cmp(v[1:0]);
            rd_chk(`DCC_OFF_STATE, {15'h0, v[1], 15'h0, v[0]});
        end
        // read-only and unmapped places
        axi_wr(`DCC_OFF_STATE, 32'hFFFF_FFFF, `DCC_RESP_OKAY);
        rd_chk(`DCC_OFF_STATE, {15'h0, v[1], 15'h0, v[0]});
        axi_wr(6'h28, 32'h1, `DCC_RESP_SLVERR);
        axi_rd(6'h28, `DCC_RESP_SLVERR);
        chk(rd_val, 32'h0);
        give_verdict();
    end
endmodule
